// file: rtl/pllcg_regs.sv
/*
  Clock generator configuration registers: word-addressed I/O slave,
  control fields driven to the generator, factor calculation.
  Assumes a single-cycle read and write strobe on the core clock.
*/

module pllcg_regs (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // CPU I/O space access
  input wire logic [15:0] io_addr_i,
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  input wire logic [15:0] io_wdata_i,
  output logic [15:0] io_rdata_o,
  output logic io_rdata_vld_o,
  // PLL controls
  output logic flop_clear_n_o,
  output logic pll_standby_o,
  output logic pll_power_off_o,
  output logic [12:0] pll_mult_o,
  output logic ref_div_skip_o,
  output logic [12:0] ref_div_value_o,
  output logic [15:0] pll_init_o,
  // Output divider and clock pin
  output logic out_div_en_o,
  output logic out_div_mode_o,
  output logic [5:0] out_div_ratio_o,
  output logic [3:0] clkout_src_o
);

  logic rst_sync_r;
  logic rst_n_r;
  logic [15:0] power_mult_r;
  logic [15:0] refdiv_mult_r;
  logic [15:0] init_lock_r;
  logic [15:0] out_div_r;
  logic [15:0] pin_src_r;
  logic [15:0] config_two_r;
  logic [15:0] rdata_nxt;
  logic sel_one;
  logic sel_two;
  logic sel_power;
  logic sel_refdiv;
  logic sel_init;
  logic sel_outdiv;
  logic sel_pinsrc;

  pllcg_cfg_if cfg_bus ();

  // Reset release through two flops
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_sync_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_sync_r <= 1'b1;
      rst_n_r <= rst_sync_r;
    end
  end

  always_comb begin
    sel_one = (io_addr_i == pllcg_pkg::ADDR_CLOCK_CONFIG_ONE);
    sel_two = (io_addr_i == pllcg_pkg::ADDR_CLOCK_CONFIG_TWO);
    sel_power = (io_addr_i == pllcg_pkg::ADDR_PLL_POWER_AND_MULT_HIGH);
    sel_refdiv = (io_addr_i == pllcg_pkg::ADDR_REF_DIVIDER_AND_MULT_LOW);
    sel_init = (io_addr_i == pllcg_pkg::ADDR_PLL_INIT_AND_LOCK);
    sel_outdiv = (io_addr_i == pllcg_pkg::ADDR_OUTPUT_DIVIDER_CONTROL);
    sel_pinsrc = (io_addr_i == pllcg_pkg::ADDR_CLOCK_PIN_SOURCE_SELECT);
  end

  // Clear, standby, power and multiplier high storage
  always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      power_mult_r <= pllcg_pkg::RST_PLL_POWER_AND_MULT_HIGH;
    end else if (io_wr_i && sel_power) begin
      power_mult_r <= io_wdata_i & pllcg_pkg::MASK_PLL_POWER_AND_MULT_HIGH;
    end
  end

  // Bypass, multiplier low and ratio storage
  always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      refdiv_mult_r <= pllcg_pkg::RST_REF_DIVIDER_AND_MULT_LOW;
    end else if (io_wr_i && sel_refdiv) begin
      refdiv_mult_r <= io_wdata_i & pllcg_pkg::MASK_REF_DIVIDER_AND_MULT_LOW;
    end
  end

  // Remaining generator registers
  always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      init_lock_r <= pllcg_pkg::RST_PLL_INIT_AND_LOCK;
      out_div_r <= pllcg_pkg::RST_OUTPUT_DIVIDER_CONTROL;
      pin_src_r <= pllcg_pkg::RST_CLOCK_PIN_SOURCE_SELECT;
      config_two_r <= pllcg_pkg::RST_CLOCK_CONFIG_TWO;
    end else if (io_wr_i) begin
      if (sel_init) begin
        init_lock_r <= io_wdata_i;
      end
      if (sel_outdiv) begin
        out_div_r <= io_wdata_i & pllcg_pkg::MASK_OUTPUT_DIVIDER_CONTROL;
      end
      if (sel_pinsrc) begin
        pin_src_r <= io_wdata_i & pllcg_pkg::MASK_CLOCK_PIN_SOURCE_SELECT;
      end
      if (sel_two) begin
        config_two_r <= io_wdata_i;
      end
    end
  end

  // Read mux; first register and unmapped read zero
  always_comb begin
    rdata_nxt = 16'h0000;
    if (sel_power) begin
      rdata_nxt = power_mult_r;
    end else if (sel_refdiv) begin
      rdata_nxt = refdiv_mult_r;
    end else if (sel_init) begin
      rdata_nxt = init_lock_r;
    end else if (sel_outdiv) begin
      rdata_nxt = out_div_r;
    end else if (sel_pinsrc) begin
      rdata_nxt = pin_src_r;
    end else if (sel_two) begin
      rdata_nxt = config_two_r;
    end
  end

  // Read data registered one cycle after the strobe
  always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      io_rdata_o <= 16'h0000;
      io_rdata_vld_o <= 1'b0;
    end else begin
      io_rdata_vld_o <= io_rd_i;
      if (io_rd_i) begin
        io_rdata_o <= rdata_nxt;
      end
    end
  end

  assign cfg_bus.mult_high = power_mult_r[pllcg_pkg::MULT_HIGH_LSB +: pllcg_pkg::MULT_HIGH_W];
  assign cfg_bus.mult_low = refdiv_mult_r[pllcg_pkg::MULT_LOW_LSB +: pllcg_pkg::MULT_LOW_W];
  assign cfg_bus.ref_div_ratio =
    refdiv_mult_r[pllcg_pkg::REF_DIV_RATIO_LSB +: pllcg_pkg::REF_DIV_RATIO_W];

  pllcg_factor pllcg_factor_inst (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_r),
    .cfg(cfg_bus.calc)
  );

  // Control outputs, each from a register bit
  // Clear control driven out
  assign flop_clear_n_o = power_mult_r[pllcg_pkg::FLOP_CLEAR_N_BIT];
  assign pll_standby_o = power_mult_r[pllcg_pkg::PLL_STANDBY_BIT];
  assign pll_power_off_o = power_mult_r[pllcg_pkg::PLL_POWER_OFF_BIT];
  assign ref_div_skip_o = refdiv_mult_r[pllcg_pkg::REF_DIV_SKIP_BIT];
  // Applied factors from the calculator flops; init word, output divider and pin source straight from registers
  assign pll_mult_o = cfg_bus.mult_value;
  assign ref_div_value_o = cfg_bus.ref_div_value;
  assign pll_init_o = init_lock_r;
  assign out_div_en_o = out_div_r[pllcg_pkg::OUT_DIV_EN_BIT];
  assign out_div_mode_o = out_div_r[pllcg_pkg::OUT_DIV_MODE_BIT];
  assign out_div_ratio_o = out_div_r[pllcg_pkg::OUT_DIV_RATIO_LSB +: pllcg_pkg::OUT_DIV_RATIO_W];
  assign clkout_src_o = pin_src_r[pllcg_pkg::CLKOUT_SRC_LSB +: pllcg_pkg::CLKOUT_SRC_W];

  // Checks
  a_decode_power_write: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_r)
    (io_wr_i && io_addr_i == 16'h1C20) |=> (power_mult_r == ($past(io_wdata_i) & 16'hB3FF))
  ) else $error("power register write not stored");

  a_unmapped_no_change: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_r)
    (io_wr_i && (io_addr_i < 16'h1C1E || io_addr_i > 16'h1C24))
      |=> $stable(power_mult_r) && $stable(refdiv_mult_r) && $stable(pin_src_r)
  ) else $error("unmapped write changed a register");

  a_clear_follows_write: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_r)
    (io_wr_i && sel_power) |=> (flop_clear_n_o == $past(io_wdata_i[15]))
  ) else $error("clear control does not follow write");

  a_standby_follows_write: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_r)
    (io_wr_i && sel_power) |=> (pll_standby_o == $past(io_wdata_i[13]))
  ) else $error("standby does not follow write");

  a_power_off_write: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_r)
    (io_wr_i && sel_power) |=> (pll_power_off_o == $past(io_wdata_i[12]))
  ) else $error("power down does not follow write");

  a_power_off_reset: assert property (
    @(posedge ref_clk_i)
    $rose(rst_n_r) |-> pll_power_off_o && !flop_clear_n_o && !ref_div_skip_o
  ) else $error("wrong control values after reset");

  a_mult_formula: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_r)
    ##1 (pll_mult_o == 13'({$past(cfg_bus.mult_high), 2'b00}) + 13'($past(cfg_bus.mult_low)) + 13'h0004)
  ) else $error("multiplier factor wrong");

  a_mult_fields_write: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_r)
    (io_wr_i && sel_power) |=> (cfg_bus.mult_high == $past(io_wdata_i[9:0]))
  ) else $error("multiplier high field not stored");

  a_mult_low_write: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_r)
    (io_wr_i && sel_refdiv) |=> (cfg_bus.mult_low == $past(io_wdata_i[13:12]))
      ##1 (pll_mult_o[1:0] == $past(io_wdata_i[13:12], 2))
  ) else $error("multiplier low field not applied");

  a_skip_follows_write: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_r)
    (io_wr_i && sel_refdiv) |=> (ref_div_skip_o == $past(io_wdata_i[15]))
  ) else $error("divider bypass does not follow write");

  a_div_value: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_r)
    (io_wr_i && sel_refdiv) |=> ##1 (ref_div_value_o == 13'($past(io_wdata_i[11:0], 2)) + 13'h0004)
  ) else $error("reference divide value wrong");

  a_reserved_read_zero: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_r)
    (io_rd_i && (sel_power || sel_one)) |=> io_rdata_vld_o
      && (io_rdata_o & ($past(sel_one) ? 16'hFFFF : 16'h4C00)) == 16'h0000
  ) else $error("reserved bits read nonzero");

  c_pll_released: cover property (
    @(posedge ref_clk_i) disable iff (!rst_n_r)
    $rose(flop_clear_n_o) && !pll_power_off_o
  );

  c_bypass_set: cover property (
    @(posedge ref_clk_i) disable iff (!rst_n_r)
    $rose(ref_div_skip_o)
  );

  c_read_back: cover property (
    @(posedge ref_clk_i) disable iff (!rst_n_r)
    (io_wr_i && sel_refdiv) ##1 (io_rd_i && sel_refdiv) ##1 io_rdata_vld_o
  );

  c_both_strobes: cover property (
    @(posedge ref_clk_i) disable iff (!rst_n_r)
    (io_wr_i && io_rd_i) ##1 io_rdata_vld_o
  );

endmodule : pllcg_regs

// file: rtl/pllcg_pkg.sv
/*
  Package of the clock generator configuration block: addresses, field
  positions, reset values and widths.
  Assumes a 16-bit CPU word-addressed I/O space on the core clock.
*/
package pllcg_pkg;

  // CPU word addresses in the I/O space
  localparam logic [15:0] ADDR_CLOCK_CONFIG_ONE = 16'h1C1E;
  localparam logic [15:0] ADDR_CLOCK_CONFIG_TWO = 16'h1C1F;
  localparam logic [15:0] ADDR_PLL_POWER_AND_MULT_HIGH = 16'h1C20;
  localparam logic [15:0] ADDR_REF_DIVIDER_AND_MULT_LOW = 16'h1C21;
  localparam logic [15:0] ADDR_PLL_INIT_AND_LOCK = 16'h1C22;
  localparam logic [15:0] ADDR_OUTPUT_DIVIDER_CONTROL = 16'h1C23;
  localparam logic [15:0] ADDR_CLOCK_PIN_SOURCE_SELECT = 16'h1C24;

  // Power and multiplier high register fields
  localparam int FLOP_CLEAR_N_BIT = 15;
  localparam int PLL_STANDBY_BIT = 13;
  localparam int PLL_POWER_OFF_BIT = 12;
  localparam int MULT_HIGH_LSB = 0;
  localparam int MULT_HIGH_W = 10;

  // Reference divider and multiplier low register fields
  localparam int REF_DIV_SKIP_BIT = 15;
  localparam int MULT_LOW_LSB = 12;
  localparam int MULT_LOW_W = 2;
  localparam int REF_DIV_RATIO_LSB = 0;
  localparam int REF_DIV_RATIO_W = 12;

  // Output divider control fields
  localparam int OUT_DIV_EN_BIT = 9;
  localparam int OUT_DIV_MODE_BIT = 8;
  localparam int OUT_DIV_RATIO_LSB = 0;
  localparam int OUT_DIV_RATIO_W = 6;

  // Clock pin source select field
  localparam int CLKOUT_SRC_LSB = 0;
  localparam int CLKOUT_SRC_W = 4;

  // Writable bit masks; other bits read as zero
  localparam logic [15:0] MASK_PLL_POWER_AND_MULT_HIGH = 16'hB3FF;
  localparam logic [15:0] MASK_REF_DIVIDER_AND_MULT_LOW = 16'hBFFF;
  localparam logic [15:0] MASK_OUTPUT_DIVIDER_CONTROL = 16'h033F;
  localparam logic [15:0] MASK_CLOCK_PIN_SOURCE_SELECT = 16'h000F;

  // Values after reset
  localparam logic [15:0] RST_PLL_POWER_AND_MULT_HIGH = 16'h1000;
  localparam logic [15:0] RST_REF_DIVIDER_AND_MULT_LOW = 16'h0000;
  localparam logic [15:0] RST_PLL_INIT_AND_LOCK = 16'h0806;
  localparam logic [15:0] RST_OUTPUT_DIVIDER_CONTROL = 16'h0000;
  localparam logic [15:0] RST_CLOCK_PIN_SOURCE_SELECT = 16'h000B;
  localparam logic [15:0] RST_CLOCK_CONFIG_TWO = 16'h0000;

  // Factor arithmetic
  localparam int FACTOR_W = 13;
  localparam logic [12:0] MULT_OFFSET = 13'h0004;
  localparam logic [12:0] REF_DIV_OFFSET = 13'h0004;

endpackage : pllcg_pkg

// file: rtl/pllcg_cfg_if.sv
/*
  Interface carrying the multiplier and divider fields to the factor
  calculator and the applied factors back.
  Assumes both ends run on the core clock.
*/
interface pllcg_cfg_if;
  logic [pllcg_pkg::MULT_HIGH_W-1:0] mult_high;
  logic [pllcg_pkg::MULT_LOW_W-1:0] mult_low;
  logic [pllcg_pkg::REF_DIV_RATIO_W-1:0] ref_div_ratio;
  logic [pllcg_pkg::FACTOR_W-1:0] mult_value;
  logic [pllcg_pkg::FACTOR_W-1:0] ref_div_value;

  modport cfg (
    output mult_high,
    output mult_low,
    output ref_div_ratio,
    input mult_value,
    input ref_div_value
  );

  modport calc (
    input mult_high,
    input mult_low,
    input ref_div_ratio,
    output mult_value,
    output ref_div_value
  );
endinterface : pllcg_cfg_if

// file: rtl/pllcg_factor.sv
/*
  Factor calculator: turns the multiplier and divider fields into the
  applied multiplication factor and reference divide value, registered.
  Assumes fields come from registers on the same clock.
*/
module pllcg_factor (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Fields in, factors out
  pllcg_cfg_if.calc cfg
);

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg.mult_value <= pllcg_pkg::MULT_OFFSET;
    end else begin
      cfg.mult_value <= {1'b0, cfg.mult_high, 2'b00}
                        + {11'h000, cfg.mult_low}
                        + pllcg_pkg::MULT_OFFSET;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg.ref_div_value <= pllcg_pkg::REF_DIV_OFFSET;
    end else begin
      cfg.ref_div_value <= {1'b0, cfg.ref_div_ratio} + pllcg_pkg::REF_DIV_OFFSET;
    end
  end

endmodule : pllcg_factor

// file: dv/pllcg_regs_bench.sv
/*
  Self-checking bench of the clock generator configuration registers.
  Assumes pllcg_regs and pllcg_pkg are compiled first; the bench alone
  drives the CPU I/O strobes, with single-cycle read and write strobes.
*/
module pllcg_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
  } pllcg_row_t;

  logic ref_clk_i;
  logic nrst_i;
  logic [15:0] io_addr_i;
  logic io_wr_i;
  logic io_rd_i;
  logic [15:0] io_wdata_i;
  logic [15:0] io_rdata_o;
  logic io_rdata_vld_o;
  logic flop_clear_n_o;
  logic pll_standby_o;
  logic pll_power_off_o;
  logic [12:0] pll_mult_o;
  logic ref_div_skip_o;
  logic [12:0] ref_div_value_o;
  logic [15:0] pll_init_o;
  logic out_div_en_o;
  logic out_div_mode_o;
  logic [5:0] out_div_ratio_o;
  logic [3:0] clkout_src_o;
  int failures;
  int checks;
  int cycles;

  pllcg_row_t rows [7] = '{
    '{pllcg_pkg::ADDR_PLL_POWER_AND_MULT_HIGH, 16'h7FFF, 16'h33FF},
    '{pllcg_pkg::ADDR_REF_DIVIDER_AND_MULT_LOW, 16'hFFFF, 16'hBFFF},
    '{pllcg_pkg::ADDR_PLL_INIT_AND_LOCK, 16'h1234, 16'h1234},
    '{pllcg_pkg::ADDR_OUTPUT_DIVIDER_CONTROL, 16'hFFFF, 16'h033F},
    '{pllcg_pkg::ADDR_CLOCK_PIN_SOURCE_SELECT, 16'hFFFF, 16'h000F},
    '{pllcg_pkg::ADDR_CLOCK_CONFIG_ONE, 16'hFFFF, 16'h0000},
    '{pllcg_pkg::ADDR_CLOCK_CONFIG_TWO, 16'hA5A5, 16'hA5A5}
  };

  pllcg_regs pllcg_regs_inst (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .io_addr_i(io_addr_i),
    .io_wr_i(io_wr_i),
    .io_rd_i(io_rd_i),
    .io_wdata_i(io_wdata_i),
    .io_rdata_o(io_rdata_o),
    .io_rdata_vld_o(io_rdata_vld_o),
    .flop_clear_n_o(flop_clear_n_o),
    .pll_standby_o(pll_standby_o),
    .pll_power_off_o(pll_power_off_o),
    .pll_mult_o(pll_mult_o),
    .ref_div_skip_o(ref_div_skip_o),
    .ref_div_value_o(ref_div_value_o),
    .pll_init_o(pll_init_o),
    .out_div_en_o(out_div_en_o),
    .out_div_mode_o(out_div_mode_o),
    .out_div_ratio_o(out_div_ratio_o),
    .clkout_src_o(clkout_src_o)
  );

  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  task automatic give_verdict();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : give_verdict

  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      $display("[FAIL] run time expected below 3000 cycles seen %0d", cycles);
      give_verdict();
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    io_addr_i <= a;
    io_wdata_i <= d;
    io_wr_i <= 1'b1;
    @(posedge ref_clk_i);
    io_wr_i <= 1'b0;
  endtask : wr

  // Read strobe, then valid exactly one cycle later and for one cycle only
  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    @(posedge ref_clk_i);
    io_addr_i <= a;
    io_rd_i <= 1'b1;
    @(posedge ref_clk_i);
    io_rd_i <= 1'b0;
    #1;
    chk("read valid", 16'h0001, {15'h0000, io_rdata_vld_o});
    chk($sformatf("read data at %h", a), exp, io_rdata_o);
    @(posedge ref_clk_i);
    #1;
    chk("read valid drop", 16'h0000, {15'h0000, io_rdata_vld_o});
  endtask : rd

  // Controls packed as clear_n, standby, power_off, skip, en, mode, src
  task automatic chk_reset();
    chk("reset controls", {6'h00, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 4'hB},
        {6'h00, flop_clear_n_o, pll_standby_o, pll_power_off_o, ref_div_skip_o,
         out_div_en_o, out_div_mode_o, clkout_src_o});
    chk("reset factor", 16'h0004, {3'h0, pll_mult_o});
    chk("reset divide", 16'h0004, {3'h0, ref_div_value_o});
    chk("reset init", 16'h0806, pll_init_o);
    rd(pllcg_pkg::ADDR_PLL_POWER_AND_MULT_HIGH, 16'h1000);
    rd(pllcg_pkg::ADDR_REF_DIVIDER_AND_MULT_LOW, 16'h0000);
    rd(pllcg_pkg::ADDR_PLL_INIT_AND_LOCK, 16'h0806);
    rd(pllcg_pkg::ADDR_OUTPUT_DIVIDER_CONTROL, 16'h0000);
    rd(pllcg_pkg::ADDR_CLOCK_PIN_SOURCE_SELECT, 16'h000B);
    rd(pllcg_pkg::ADDR_CLOCK_CONFIG_ONE, 16'h0000);
    rd(pllcg_pkg::ADDR_CLOCK_CONFIG_TWO, 16'h0000);
  endtask : chk_reset

  initial begin
    nrst_i = 1'b0;
    io_addr_i = 16'h0000;
    io_wr_i = 1'b0;
    io_rd_i = 1'b0;
    io_wdata_i = 16'h0000;
    repeat (5) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wdata);
      rd(rows[i].addr, rows[i].rdata);
    end
    rd(16'h1C25, 16'h0000);
    rd(16'h1C1D, 16'h0000);
    // All fields at their top values except clear_n, left low by the 7FFF write
    chk("top controls", 16'h007F, {8'h00, flop_clear_n_o, pll_standby_o, pll_power_off_o,
        ref_div_skip_o, out_div_en_o, out_div_mode_o, 2'h3});
    chk("top factor", 16'h1003, {3'h0, pll_mult_o});
    chk("top divide", 16'h1003, {3'h0, ref_div_value_o});
    chk("init word", 16'h1234, pll_init_o);
    chk("out ratio src", 16'h3F0F, {2'h0, out_div_ratio_o, 4'h0, clkout_src_o});
    // Running setup, factor 8F1h, ratio 3 divides by 7
    // Divider set under clear, init word, then release
    wr(pllcg_pkg::ADDR_REF_DIVIDER_AND_MULT_LOW, 16'h1003);
    wr(pllcg_pkg::ADDR_PLL_INIT_AND_LOCK, 16'h0806);
    // Mode switch stays outside, never selected here
    wr(pllcg_pkg::ADDR_PLL_POWER_AND_MULT_HIGH, 16'h823B);
    #1;
    chk("run controls", 16'h0008, {12'h000, flop_clear_n_o, pll_standby_o, pll_power_off_o,
        ref_div_skip_o});
    chk("run init", 16'h0806, pll_init_o);
    @(posedge ref_clk_i);
    #1;
    chk("run factor", 16'h08F1, {3'h0, pll_mult_o});
    chk("run divide", 16'h0007, {3'h0, ref_div_value_o});
    // Read and write together return the old word
    @(posedge ref_clk_i);
    io_addr_i <= pllcg_pkg::ADDR_CLOCK_PIN_SOURCE_SELECT;
    io_wdata_i <= 16'h0003;
    io_wr_i <= 1'b1;
    io_rd_i <= 1'b1;
    @(posedge ref_clk_i);
    io_wr_i <= 1'b0;
    io_rd_i <= 1'b0;
    #1;
    chk("both strobes data", 16'h000F, io_rdata_o);
    chk("both strobes src", 16'h0003, {12'h000, clkout_src_o});
    // Write then read in back-to-back cycles
    @(posedge ref_clk_i);
    io_addr_i <= pllcg_pkg::ADDR_CLOCK_CONFIG_TWO;
    io_wdata_i <= 16'h5A5A;
    io_wr_i <= 1'b1;
    @(posedge ref_clk_i);
    io_wr_i <= 1'b0;
    io_rd_i <= 1'b1;
    @(posedge ref_clk_i);
    io_rd_i <= 1'b0;
    #1;
    chk("back to back", 16'h5A5A, io_rdata_o);
    // Reset in mid-run acts at once
    @(posedge ref_clk_i);
    nrst_i <= 1'b0;
    #1;
    chk("async power off", 16'h0001, {15'h0000, pll_power_off_o});
    repeat (5) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    #1;
    chk_reset();
    give_verdict();
  end
endmodule : pllcg_regs_bench
